// *** hdl/sbcd_top.sv ***
/*
  status bus command decoder: turns the processor's three status lines into
  memory, i/o and interrupt acknowledge strobes plus latch and transceiver
  controls. assumes status, grant, qualifier and strap are synchronous to
  i_clk; tri-state pins are split into output and active-low output enable.
*/
// Overview of operation
// - codes 000 irq ack, 001 io read, 010 io write plus early; 011 none
// - codes 100 and 101 memory read; 110 memory write plus early; 111 none
// - command drivers enable only after grant low for minimum delay
// - grant release floats command drivers at once, without a clock edge
// - in io bus mode, io command lines ignore the bus grant
// - strap high selects io bus mode, low selects system bus mode
// - qualifier low forces commands, data enables inactive
// - early io write strobe asserts with read timing, before io write
// - early memory write strobe asserts with read timing, before write
// - address latch strobe is active high; latches close on its fall
// - data transceiver enable is active high while data connects
// - direction high for writes, low for reads
// - interrupt acknowledge strobe is active low
// - io read strobe is active low
// - io write strobe is active low
// - memory read strobe is active low
// - memory write strobe is active low
// - system bus mode: dual output is active-high cascade gate on irq ack
// - io bus mode: dual output is active-low peripheral data enable
// - idle status lines read high and decode as passive
// - outputs are timed from the processor clock, except the combinational grant, qualifier and strap gating
// - latch strobe pulses each cycle and captures status for halt
// - irq ack is two back-to-back cycles; vector read in second
`timescale 1ns/100ps
`include "sbcd_consts.svh"

module sbcd_top
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_cpu_status_bit0_n,
  input  wire logic              i_cpu_status_bit1_n,
  input  wire logic              i_cpu_status_bit2_n,
  input  wire logic              i_bus_mode_strap,
  input  wire logic              i_bus_grant_n,
  input  wire logic              i_command_qualifier,
  output sbcd_pkg::sbcd_cmd_t    o_cmd,
  output sbcd_pkg::sbcd_cmd_t    o_cmd_oe_n,
  output logic                   o_addr_latch_strobe,
  output logic                   o_xcvr_enable,
  output logic                   o_xcvr_direction,
  output logic                   o_master_cascade_gate,
  output logic                   o_periph_xcvr_enable_n,
  output logic                   o_halted
);
  import sbcd_pkg::*;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic sbcd_cmd_t cmd_of(input logic [2:0] code);
    sbcd_cmd_t c;
    c = '1;
    case (code)
      `SBCD_ST_IRQ_ACK:    c.irq_ack_strobe_n = 1'b0;
      `SBCD_ST_IO_READ:    c.io_read_strobe_n = 1'b0;
      `SBCD_ST_IO_WRITE:   c.io_write_strobe_n = 1'b0;
      `SBCD_ST_CODE_FETCH: c.mem_read_strobe_n = 1'b0;
      `SBCD_ST_MEM_READ:   c.mem_read_strobe_n = 1'b0;
      `SBCD_ST_MEM_WRITE:  c.mem_write_strobe_n = 1'b0;
      default:             c = '1;
    endcase
    return c;
  endfunction

  function automatic logic is_io(input logic [2:0] code);
    return !code[2] && (code != `SBCD_ST_HALT);
  endfunction

  function automatic logic is_write(input logic [2:0] code);
    return (code == `SBCD_ST_IO_WRITE) || (code == `SBCD_ST_MEM_WRITE);
  endfunction

  function automatic logic has_command(input logic [2:0] code);
    return (code != `SBCD_ST_HALT) && (code != `SBCD_ST_PASSIVE);
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [2:0]  status;
  logic        io_mode;
  logic        grant_ready;
  sbcd_state_t state_q, state_d;
  logic [2:0]  code_q, code_d;
  logic        halted_q, halted_d;
  logic        ack_second_q, ack_second_d;
  logic        ale_q, ale_d;
  logic        early_q, early_d;
  logic        late_q, late_d;
  logic        den_q, den_d;
  logic        dir_q, dir_d;
  logic        mce_q, mce_d;
  logic        gate_sys, gate_io;
  sbcd_cmd_t   early_cmd, late_cmd, cmd_raw;

  // idle lines are pulled high by the pads, so all ones is passive
  assign status  = {i_cpu_status_bit2_n, i_cpu_status_bit1_n,
                    i_cpu_status_bit0_n};
  assign io_mode = i_bus_mode_strap;

  sbcd_grant_timer u_grant_timer
  (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_bus_grant_n (i_bus_grant_n),
    .o_grant_ready (grant_ready)
  );

  // --------------------------------------------------------------------------
  // bus cycle sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    code_d  = code_q;
    case (state_q)
      SBCD_IDLE:
      begin
        if (status != `SBCD_ST_PASSIVE)
        begin
          state_d = SBCD_ADDR;
          code_d  = status;
        end
      end
      SBCD_ADDR:
        state_d = SBCD_CMD;
      SBCD_CMD:
      begin
        // other codes while a command stands are ignored
        if (status == `SBCD_ST_PASSIVE)
          state_d = SBCD_END;
      end
      SBCD_END:
        state_d = SBCD_IDLE;
      default:
        state_d = SBCD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= SBCD_IDLE;
      code_q  <= `SBCD_ST_PASSIVE;
    end
    else
    begin
      state_q <= state_d;
      code_q  <= code_d;
    end
  end

  // --------------------------------------------------------------------------
  // command phase registers
  // --------------------------------------------------------------------------
  always_comb
  begin
    ale_d   = 1'b0;
    early_d = early_q;
    late_d  = late_q;
    den_d   = den_q;
    dir_d   = dir_q;
    mce_d   = 1'b0;
    case (state_q)
      SBCD_IDLE:
      begin
        if (status != `SBCD_ST_PASSIVE)
        begin
          ale_d = 1'b1;
          dir_d = is_write(status);
          // cascade address goes out just before the second acknowledge
          mce_d = (status == `SBCD_ST_IRQ_ACK) && ack_second_q;
        end
      end
      SBCD_ADDR:
      begin
        // read-type timing: early strobes lead the normal write
        early_d = has_command(code_q);
        den_d   = has_command(code_q);
      end
      SBCD_CMD:
      begin
        late_d = has_command(code_q);
        if (status == `SBCD_ST_PASSIVE)
        begin
          early_d = 1'b0;
          late_d  = 1'b0;
          den_d   = 1'b0;
        end
      end
      SBCD_END:
        dir_d = 1'b0;
      default:
      begin
        early_d = 1'b0;
        late_d  = 1'b0;
        den_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ale_q   <= 1'b0;
      early_q <= 1'b0;
      late_q  <= 1'b0;
      den_q   <= 1'b0;
      dir_q   <= 1'b0;
      mce_q   <= 1'b0;
    end
    else
    begin
      ale_q   <= ale_d;
      early_q <= early_d;
      late_q  <= late_d;
      den_q   <= den_d;
      dir_q   <= dir_d;
      mce_q   <= mce_d;
    end
  end

  // --------------------------------------------------------------------------
  // cycle history: halt latch and acknowledge pairing
  // --------------------------------------------------------------------------
  always_comb
  begin
    halted_d     = halted_q;
    ack_second_d = ack_second_q;
    // refreshed by every latch strobe, so a halt does not stick forever
    if (state_q == SBCD_IDLE && status != `SBCD_ST_PASSIVE)
      halted_d = (status == `SBCD_ST_HALT);
    // any other cycle breaks a pair, so a stray ack restarts the count
    if (state_q == SBCD_END)
    begin
      if (code_q == `SBCD_ST_IRQ_ACK)
        ack_second_d = !ack_second_q;
      else
        ack_second_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      halted_q     <= 1'b0;
      ack_second_q <= 1'b0;
    end
    else
    begin
      halted_q     <= halted_d;
      ack_second_q <= ack_second_d;
    end
  end

  // --------------------------------------------------------------------------
  // strobe shaping and qualification
  // --------------------------------------------------------------------------
  always_comb
  begin
    early_cmd = '1;
    late_cmd  = '1;
    if (early_q)
    begin
      early_cmd = cmd_of(code_q);
      // normal writes wait one cycle; early ones take read timing
      early_cmd.io_write_strobe_n  = 1'b1;
      early_cmd.mem_write_strobe_n = 1'b1;
      early_cmd.early_io_write_strobe_n =
        !(code_q == `SBCD_ST_IO_WRITE);
      early_cmd.early_mem_write_strobe_n =
        !(code_q == `SBCD_ST_MEM_WRITE);
    end
    if (late_q)
      late_cmd = cmd_of(code_q);
    cmd_raw = early_cmd & late_cmd;
    if (!i_command_qualifier)
      cmd_raw = '1;
  end

  // drivers: grant gating is combinational so release floats at once
  assign gate_sys = grant_ready;
  assign gate_io  = io_mode ? 1'b1 : grant_ready;

  assign o_cmd = cmd_raw;
  always_comb
  begin
    o_cmd_oe_n = '1;
    o_cmd_oe_n.mem_read_strobe_n        = !gate_sys;
    o_cmd_oe_n.mem_write_strobe_n       = !gate_sys;
    o_cmd_oe_n.early_mem_write_strobe_n = !gate_sys;
    o_cmd_oe_n.io_read_strobe_n         = !gate_io;
    o_cmd_oe_n.io_write_strobe_n        = !gate_io;
    o_cmd_oe_n.early_io_write_strobe_n  = !gate_io;
    o_cmd_oe_n.irq_ack_strobe_n         = !gate_io;
  end

  // --------------------------------------------------------------------------
  // control outputs
  // --------------------------------------------------------------------------
  assign o_addr_latch_strobe = ale_q;
  assign o_xcvr_direction    = dir_q;
  assign o_halted            = halted_q;
  // in io mode the i/o transfers use the peripheral enable instead
  assign o_xcvr_enable = den_q && i_command_qualifier &&
                         !(io_mode && is_io(code_q));
  assign o_periph_xcvr_enable_n = !(io_mode && den_q &&
                         i_command_qualifier && is_io(code_q));
  assign o_master_cascade_gate  = !io_mode && mce_q;

endmodule

// *** hdl/sbcd_consts.svh ***
/*
  timing counts and status code values for the status bus command decoder.
  assumes a 100 MHz system clock; included by the package users.
*/
`ifndef SBCD_CONSTS_SVH
`define SBCD_CONSTS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SBCD_CLK_PERIOD_NS      10
`define SBCD_GRANT_DELAY_NS     100
`define SBCD_GRANT_DELAY_CYC    \
  ((`SBCD_GRANT_DELAY_NS + `SBCD_CLK_PERIOD_NS - 1) / `SBCD_CLK_PERIOD_NS)
`define SBCD_GRANT_CNT_W        4

// ----------------------------------------------------------------------------
// status codes (bit2, bit1, bit0)
// ----------------------------------------------------------------------------
`define SBCD_ST_IRQ_ACK         3'h0
`define SBCD_ST_IO_READ         3'h1
`define SBCD_ST_IO_WRITE        3'h2
`define SBCD_ST_HALT            3'h3
`define SBCD_ST_CODE_FETCH      3'h4
`define SBCD_ST_MEM_READ        3'h5
`define SBCD_ST_MEM_WRITE       3'h6
`define SBCD_ST_PASSIVE         3'h7

`endif

// *** hdl/sbcd_pkg.sv ***
/*
  types shared by the status bus command decoder and its grant timer.
  assumes nothing beyond the constants header.
*/
package sbcd_pkg;

  // --------------------------------------------------------------------------
  // command strobes, all active low
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic early_mem_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic early_io_write_strobe_n;
    logic irq_ack_strobe_n;
  } sbcd_cmd_t;

  // --------------------------------------------------------------------------
  // bus cycle phases
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SBCD_IDLE  = 4'b0001,
    SBCD_ADDR  = 4'b0010,
    SBCD_CMD   = 4'b0100,
    SBCD_END   = 4'b1000
  } sbcd_state_t;

endpackage

// *** hdl/sbcd_grant_timer.sv ***
/*
  grant timer: reports grant ready once the active-low bus grant has been
  low for the minimum enable delay. assumes a synchronous grant input.
*/
`timescale 1ns/100ps
`include "sbcd_consts.svh"

module sbcd_grant_timer
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_bus_grant_n,
  output logic      o_grant_ready
);
  import sbcd_pkg::*;

  localparam logic [`SBCD_GRANT_CNT_W-1:0] DELAY_CYC =
    (`SBCD_GRANT_CNT_W)'(`SBCD_GRANT_DELAY_CYC);

  logic [`SBCD_GRANT_CNT_W-1:0] cnt_q;
  logic [`SBCD_GRANT_CNT_W-1:0] cnt_d;

  // --------------------------------------------------------------------------
  // count while granted; release clears the count at the next clock edge
  // --------------------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    if (i_bus_grant_n)
      cnt_d = '0;
    else if (cnt_q != DELAY_CYC)
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  // combinational drop on release, no clock edge needed
  assign o_grant_ready = !i_bus_grant_n && (cnt_q == DELAY_CYC);

endmodule

// *** tb/sbcd_properties.sv ***
/*
  checker for the status bus command decoder, on its top ports.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps

module sbcd_checker
(
  input wire logic                i_clk,
  input wire logic                i_sys_rst,
  input wire logic                i_cpu_status_bit0_n,
  input wire logic                i_cpu_status_bit1_n,
  input wire logic                i_cpu_status_bit2_n,
  input wire logic                i_bus_mode_strap,
  input wire logic                i_bus_grant_n,
  input wire logic                i_command_qualifier,
  input wire sbcd_pkg::sbcd_cmd_t o_cmd,
  input wire sbcd_pkg::sbcd_cmd_t o_cmd_oe_n,
  input wire logic                o_addr_latch_strobe,
  input wire logic                o_xcvr_enable,
  input wire logic                o_xcvr_direction,
  input wire logic                o_master_cascade_gate,
  input wire logic                o_periph_xcvr_enable_n
);
  import sbcd_pkg::*;

  // ----
  // helpers
  // ----
  logic [2:0] st;
  logic [3:0] gnt_q;
  logic [3:0] gnt_d;

  assign st = {i_cpu_status_bit2_n, i_cpu_status_bit1_n, i_cpu_status_bit0_n};

  // saturates so a long grant never wraps back into the wait window
  always_comb
  begin
    gnt_d = gnt_q;
    if (i_bus_grant_n)
      gnt_d = 4'h0;
    else if (gnt_q != 4'hF)
      gnt_d = gnt_q + 4'h1;
  end

  always_ff @(posedge i_clk)
    gnt_q <= i_sys_rst ? 4'h0 : gnt_d;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ----
  // properties
  // ----
  a_grant_float:
    assert property (i_bus_grant_n && !i_bus_mode_strap |-> &o_cmd_oe_n)
      else $error("drivers on without grant");
  a_grant_wait:
    assert property (gnt_q < 4'hA |-> o_cmd_oe_n.mem_read_strobe_n)
      else $error("drivers on too early");
  a_grant_on:
    assert property (gnt_q == 4'hF && !i_bus_grant_n
      |-> !o_cmd_oe_n.mem_read_strobe_n) else $error("drivers stay off");
  a_io_ungated:
    assert property (i_bus_mode_strap |-> !o_cmd_oe_n.io_read_strobe_n
      && !o_cmd_oe_n.io_write_strobe_n) else $error("io lines gated");
  a_qual_forces:
    assert property (!i_command_qualifier |-> &o_cmd && !o_xcvr_enable
      && o_periph_xcvr_enable_n) else $error("qualifier ignored");
  a_early_io:
    assert property ($fell(o_cmd.io_write_strobe_n)
      |-> !$past(o_cmd.early_io_write_strobe_n)) else $error("io early late");
  a_early_mem:
    assert property ($fell(o_cmd.mem_write_strobe_n)
      |-> !$past(o_cmd.early_mem_write_strobe_n)) else $error("mem early late");
  a_ale_pulse:
    assert property (o_addr_latch_strobe |=> !o_addr_latch_strobe)
      else $error("latch strobe too long");
  a_mem_write:
    assert property (o_addr_latch_strobe && st == 3'h6 && i_command_qualifier
      |=> !o_cmd.early_mem_write_strobe_n && o_xcvr_direction
      ##1 !o_cmd.mem_write_strobe_n) else $error("mem write wrong");
  a_mem_read:
    assert property (o_addr_latch_strobe && st == 3'h5 && i_command_qualifier
      |=> !o_cmd.mem_read_strobe_n && o_xcvr_enable) else $error("mem read");
  a_irq_ack:
    assert property (o_addr_latch_strobe && st == 3'h0 && i_command_qualifier
      |=> !o_cmd.irq_ack_strobe_n) else $error("irq ack missing");
  a_cascade_mode:
    assert property (o_master_cascade_gate |-> o_addr_latch_strobe
      && !i_bus_mode_strap) else $error("cascade gate misplaced");
endmodule

bind sbcd_top sbcd_checker u_chk
(
  .i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_cpu_status_bit0_n(i_cpu_status_bit0_n),
  .i_cpu_status_bit1_n(i_cpu_status_bit1_n),
  .i_cpu_status_bit2_n(i_cpu_status_bit2_n),
  .i_bus_mode_strap(i_bus_mode_strap), .i_bus_grant_n(i_bus_grant_n),
  .i_command_qualifier(i_command_qualifier), .o_cmd(o_cmd),
  .o_cmd_oe_n(o_cmd_oe_n), .o_addr_latch_strobe(o_addr_latch_strobe),
  .o_xcvr_enable(o_xcvr_enable), .o_xcvr_direction(o_xcvr_direction),
  .o_master_cascade_gate(o_master_cascade_gate),
  .o_periph_xcvr_enable_n(o_periph_xcvr_enable_n)
);

// *** tb/sbcd_cpu_model.sv ***
/*
  processor model: drives the status code and the bus grant.
  assumes tasks are called only between bus cycles.
*/
`timescale 1ns/100ps

module sbcd_cpu_model
(
  input  wire logic  i_clk,
  output logic [2:0] o_status_n,
  output logic       o_bus_grant_n
);
  // ----
  // stimulus
  // ----
  initial
  begin
    o_status_n = 3'h7;
    o_bus_grant_n = 1'b1;
  end

  // hold sets how slowly the processor ends the cycle
  task automatic bus_cycle(input logic [2:0] code, input int hold);
    @(posedge i_clk);
    #1 o_status_n = code;
    repeat (hold) @(posedge i_clk);
    #1 o_status_n = 3'h7;
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic grant(input logic level_n);
    @(posedge i_clk);
    #1 o_bus_grant_n = level_n;
  endtask
endmodule

// *** tb/status_bus_command_decoder_bench.sv ***
/*
  self-checking bench for the status bus command decoder.
  assumes the processor model drives status and grant.
*/
`timescale 1ns/100ps

module status_bus_command_decoder_bench;
  import sbcd_pkg::*;

  // ----
  // signals
  // ----
  logic       i_clk, i_sys_rst, strap, qual, grant_n;
  logic [2:0] st_n;
  sbcd_cmd_t  cmd, oe_n;
  logic       ale, xcvr_enable, dir, master_cascade_gate, periph_xcvr_enable_n_n, halted;
  logic [9:0] exp_q[$];
  int         miscompares = 0;
  int         n_checks = 0;
  int         n_mce = 0;
  int         n;

  sbcd_top dut
  (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_cpu_status_bit0_n(st_n[0]), .i_cpu_status_bit1_n(st_n[1]),
    .i_cpu_status_bit2_n(st_n[2]), .i_bus_mode_strap(strap),
    .i_bus_grant_n(grant_n), .i_command_qualifier(qual),
    .o_cmd(cmd), .o_cmd_oe_n(oe_n), .o_addr_latch_strobe(ale),
    .o_xcvr_enable(xcvr_enable), .o_xcvr_direction(dir),
    .o_master_cascade_gate(master_cascade_gate), .o_periph_xcvr_enable_n(periph_xcvr_enable_n_n),
    .o_halted(halted)
  );

  sbcd_cpu_model cpu
  (
    .i_clk(i_clk), .o_status_n(st_n), .o_bus_grant_n(grant_n)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----
  // checking
  // ----
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // {strobes, data enable, direction, peripheral enable} seen mid-command
  function automatic logic [9:0] expect_of(input logic [2:0] c,
                                           input logic q, input logic s);
    sbcd_cmd_t x;
    logic      io;
    x = 7'h7F;
    io = (c < 3'h3);
    if (q)
    begin
      x.irq_ack_strobe_n = (c != 3'h0);
      x.io_read_strobe_n = (c != 3'h1);
      x.io_write_strobe_n = (c != 3'h2);
      x.early_io_write_strobe_n = (c != 3'h2);
      x.mem_read_strobe_n = !(c == 3'h4 || c == 3'h5);
      x.mem_write_strobe_n = (c != 3'h6);
      x.early_mem_write_strobe_n = (c != 3'h6);
    end
    return {x, q && c != 3'h3 && !(s && io), c == 3'h2 || c == 3'h6,
            !(q && s && io)};
  endfunction

  // by the second cycle after the latch strobe every strobe is settled
  initial
    forever
    begin
      @(negedge i_clk);
      if (ale === 1'b1)
      begin
        repeat (2) @(negedge i_clk);
        check({cmd, xcvr_enable, dir, periph_xcvr_enable_n_n}, exp_q.pop_front());
      end
    end

  always @(negedge i_clk)
    if (master_cascade_gate === 1'b1)
      n_mce++;

  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #50000;
    miscompares++;
    complete_run;
  end

  // ----
  // tests
  // ----
  initial
  begin
    i_sys_rst = 1'b1;
    strap = 1'b0;
    qual = 1'b1;
    void'($urandom(32'h5B1088A7));
    repeat (6) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    cpu.grant(1'b0);
    n = 0;
    while (oe_n.mem_read_strobe_n !== 1'b0 && n < 40)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    check(10'(n), 10'h00A);
    cpu.grant(1'b1);
    #1 check({3'h0, oe_n}, 10'h07F);
    cpu.grant(1'b0);
    repeat (12) @(posedge i_clk);
    #1 $display("test grant done");
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 7; c++)
      begin
        strap = m[0];
        qual = (m == 0) || ((c != 4) && ($urandom % 2 == 0));
        exp_q.push_back(expect_of(c[2:0], qual, strap));
        cpu.bus_cycle(c[2:0], 4 + $urandom % 3);
        check({3'h0, cmd}, 10'h07F);
        check({9'h000, halted}, (c == 3) ? 10'h001 : 10'h000);
      end
    $display("test decode done");
    qual = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      strap = m[0];
      n = n_mce;
      repeat (2)
      begin
        exp_q.push_back(expect_of(3'h0, 1'b1, strap));
        cpu.bus_cycle(3'h0, 4);
      end
      check(10'(n_mce - n), m ? 10'h000 : 10'h001);
    end
    $display("test cascade done");
    complete_run;
  end
endmodule
